// ==== include/arc_pkg.sv ====
package arc_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_RATE = 8'h04;
    localparam logic [7:0] ADDR_REF = 8'h05;
    localparam logic [7:0] ADDR_EXC = 8'h06;
    localparam logic [7:0] RESET_RATE = 8'h14;
    localparam logic [7:0] RESET_REF = 8'h10;
    localparam logic [7:0] RESET_EXC = 8'h00;
    localparam logic [7:0] EXC_WRITE_MASK = 8'hcf;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int RATE_CHOP_BIT = 7;
    localparam int RATE_CLK_BIT = 6;
    localparam int RATE_MODE_BIT = 5;
    localparam int RATE_FILTER_BIT = 4;
    localparam int REF_POS_BUF_BIT = 5;
    localparam int REF_NEG_BUF_BIT = 4;
    localparam int EXC_RAIL_BIT = 7;
    localparam int EXC_SWITCH_BIT = 6;
    // ---------------------------------------------------------------
    // Field codes
    // ---------------------------------------------------------------
    localparam logic [3:0] RATE_CODE_RESERVED = 4'hf;
    localparam logic [1:0] MON_OFF = 2'h0;
    localparam logic [1:0] MON_LOW = 2'h1;
    localparam logic [1:0] MON_LOW_THIRD = 2'h2;
    localparam logic [1:0] MON_LOW_PULL = 2'h3;
    localparam logic [1:0] REFSRC_RESERVED = 2'h3;
    localparam logic [1:0] IREF_OFF = 2'h0;
    localparam logic [1:0] IREF_ON_PD_OFF = 2'h1;
    localparam logic [1:0] IREF_ALWAYS = 2'h2;
    localparam logic [3:0] EXC_CURRENT_OFF = 4'h0;
    // ---------------------------------------------------------------
    // Conversion sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ARC_IDLE = 2'b00,
        ARC_CONVERT = 2'b01,
        ARC_DONE = 2'b10
    } arc_conv_state_t;
endpackage : arc_pkg

// ==== tb/adc_rate_reference_config_tb.sv ====
`timescale 1ns/1ps
module adc_rate_reference_config_tb;
    import arc_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic power_down = 1'b0;
    logic start_conversion = 1'b0;
    logic sample_done = 1'b0;
    logic reg_write, reg_read;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val, v;
    logic chop_enable, chop_swap, external_clock_select, single_shot_mode;
    logic low_latency_filter, rate_code_valid, converting;
    logic ref_low_threshold_monitor, ref_third_span_monitor, ref_pull_together;
    logic pos_ref_buffer_bypass, neg_ref_buffer_bypass, reference_select_valid;
    logic internal_ref_on, output_rail_monitor_enable, low_side_switch_close;
    logic [3:0] output_rate_code, excitation_current_magnitude;
    logic [1:0] reference_input_select;
    logic [7:0] rate_v [6] = '{8'h80, 8'h40, 8'h20, 8'h00, 8'h1b, 8'h0f};
    logic [7:0] ref_v [7] = '{8'h40, 8'h80, 8'hc0, 8'h20, 8'h0d, 8'h01, 8'h02};
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;

    always #4 clk = ~clk;

    arc_host_model i_arc_host_model (.clk, .reg_write, .reg_read, .reg_addr,
        .reg_wdata, .reg_rdata);
    arc_config i_arc_config (.clk, .reset, .reg_write, .reg_read, .reg_addr,
        .reg_wdata, .power_down, .start_conversion, .sample_done, .reg_rdata,
        .chop_enable, .chop_swap, .external_clock_select, .single_shot_mode,
        .low_latency_filter, .output_rate_code, .rate_code_valid, .converting,
        .ref_low_threshold_monitor, .ref_third_span_monitor, .ref_pull_together,
        .pos_ref_buffer_bypass, .neg_ref_buffer_bypass, .reference_input_select,
        .reference_select_valid, .internal_ref_on, .output_rail_monitor_enable,
        .low_side_switch_close, .excitation_current_magnitude);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // Decoded outputs lag the register by one more edge
    task automatic wr_settle(input logic [7:0] a, input logic [7:0] d);
        i_arc_host_model.wr(a, d);
        @(negedge clk);
    endtask : wr_settle

    // One result strobe, then time for the sequencer outputs to follow
    task automatic pulse_sample();
        sample_done = 1'b1;
        @(negedge clk);
        sample_done = 1'b0;
        repeat (2) @(negedge clk);
    endtask : pulse_sample

    function automatic logic [7:0] rate_seen();
        return {chop_enable, external_clock_select, single_shot_mode,
            low_latency_filter, output_rate_code};
    endfunction : rate_seen

    function automatic logic [7:0] ref_seen();
        return {ref_low_threshold_monitor, ref_third_span_monitor, ref_pull_together,
            pos_ref_buffer_bypass, neg_ref_buffer_bypass, reference_input_select,
            reference_select_valid};
    endfunction : ref_seen

    function automatic logic [7:0] ref_exp(input logic [7:0] r);
        return {r[7:6] != 2'h0, r[7:6] == 2'h2, r[7:6] == 2'h3, r[5:2], r[3:2] != 2'h3};
    endfunction : ref_exp

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            conclude();
        end
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (3) @(negedge clk);
        reset = 1'b0;
        i_arc_host_model.rd(ADDR_RATE, rd_val);
        chk("rate_reset", 8'h14, rd_val);
        chk("rate_fields_reset", 8'h14, rate_seen());
        i_arc_host_model.rd(ADDR_REF, rd_val);
        chk("ref_reset", 8'h10, rd_val);
        i_arc_host_model.rd(ADDR_EXC, rd_val);
        chk("exc_reset", 8'h00, rd_val);
        chk("exc_out_reset", 8'h00, {output_rail_monitor_enable, low_side_switch_close,
            2'h0, excitation_current_magnitude});
        foreach (rate_v[i]) begin
            wr_settle(ADDR_RATE, rate_v[i]);
            chk("rate_fields", rate_v[i], rate_seen());
            chk("rate_valid", {7'h0, rate_v[i][3:0] != 4'hf}, {7'h0, rate_code_valid});
            i_arc_host_model.rd(ADDR_RATE, rd_val);
            chk("rate_read", rate_v[i], rd_val);
        end
        foreach (ref_v[i]) begin
            v = ref_v[i];
            wr_settle(ADDR_REF, v);
            chk("ref_fields", ref_exp(v), ref_seen());
            for (int pd = 0; pd < 2; pd++) begin
                power_down = pd[0];
                repeat (2) @(negedge clk);
                rd_val = {7'h0, v[1:0] == 2'h2 || (v[1:0] == 2'h1 && pd == 0)};
                chk("iref_on", rd_val, {7'h0, internal_ref_on});
            end
            power_down = 1'b0;
            i_arc_host_model.rd(ADDR_REF, rd_val);
            chk("ref_read", v, rd_val);
        end
        wr_settle(ADDR_EXC, 8'hff);
        i_arc_host_model.rd(ADDR_EXC, rd_val);
        chk("exc_read", 8'hcf, rd_val);
        chk("exc_out", 8'hcf, {output_rail_monitor_enable, low_side_switch_close,
            2'h0, excitation_current_magnitude});
        power_down = 1'b1;
        repeat (2) @(negedge clk);
        chk("switch_pd", 8'h00, {7'h0, low_side_switch_close});
        power_down = 1'b0;
        i_arc_host_model.excite(4'h1);
        @(negedge clk);
        chk("exc_mag", 8'h01, {4'h0, excitation_current_magnitude});
        chk("exc_iref", 8'h01, {7'h0, internal_ref_on});
        wr_settle(8'h07, 8'hff);
        i_arc_host_model.rd(8'h07, rd_val);
        chk("unmapped_read", 8'h00, rd_val);
        i_arc_host_model.rd(ADDR_RATE, rd_val);
        chk("rate_after_unmapped", 8'h0f, rd_val);
        wr_settle(ADDR_RATE, 8'h94);
        start_conversion = 1'b1;
        @(negedge clk);
        start_conversion = 1'b0;
        for (int k = 0; k < 8 && converting !== 1'b1; k++) @(negedge clk);
        chk("converting", 8'h01, {7'h0, converting});
        sample_done = 1'b1;
        @(negedge clk);
        sample_done = 1'b0;
        for (int k = 0; k < 8 && chop_swap !== 1'b1; k++) @(negedge clk);
        chk("chop_swap", 8'h01, {7'h0, chop_swap});
        wr_settle(ADDR_RATE, 8'hb4);
        pulse_sample();
        chk("single_shot_end", 8'h00, {7'h0, converting});
        start_conversion = 1'b1;
        @(negedge clk);
        start_conversion = 1'b0;
        pulse_sample();
        chk("chop_first_half", 8'h01, {7'h0, converting});
        chk("chop_first_swap", 8'h01, {7'h0, chop_swap});
        pulse_sample();
        chk("chop_pair_end", 8'h00, {7'h0, converting});
        chk("chop_pair_swap", 8'h00, {7'h0, chop_swap});
        reset = 1'b1;
        @(negedge clk);
        reset = 1'b0;
        i_arc_host_model.rd(ADDR_RATE, rd_val);
        chk("rate_rereset", 8'h14, rd_val);
        conclude();
    end
endmodule : adc_rate_reference_config_tb

// ==== tb/arc_host_model.sv ====
`timescale 1ns/1ps
module arc_host_model
    import arc_pkg::*;
(
    input wire logic clk,
    output logic reg_write,
    output logic reg_read,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_write = 1'b0;
        // Released bus never shows a stale value
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_read = 1'b1;
        reg_addr = a;
        @(negedge clk);
        d = reg_rdata;
        reg_read = 1'b0;
        reg_addr = ~a;
    endtask : rd

    task automatic excite(input logic [3:0] mag);
        wr(ADDR_REF, 8'h3a);
        wr(ADDR_EXC, {4'h0, mag});
    endtask : excite
endmodule : arc_host_model

// ==== verilog/arc_config.sv ====
// Functional notes
// RULE1 - Rate register at 04h, reset 14h
// RULE2 - Bit 7 enables global chop, averaging pairs
// RULE3 - Bit 6 selects internal or external clock
// RULE4 - Bit 5: continuous or single-shot conversions
// RULE5 - Bit 4: sinc3 or low-latency filter
// RULE6 - Bits 3:0 set data rate; 1111 reserved
// RULE7 - Reference monitor field modes in bits 7:6
// RULE8 - Bit 5 bypasses positive reference buffer
// RULE9 - Bit 4 bypasses negative reference buffer
// RULE10 - Bits 3:2 select reference source
// RULE11 - Bits 1:0 control internal reference power
// RULE12 - Host bypasses buffers with internal reference
// RULE13 - Host enables reference before excitation currents
// RULE14 - Reference register at 05h, reset 10h
// RULE15 - Excitation register at 06h, reset 00h
// RULE16 - Switch closes on bit, opens in power-down
// RULE17 - Magnitude field sets both currents; 0 off
// RULE18 - Rail monitor enable bit, off at reset
// RULE19 - Excitation bits 5:4 ignore writes, read zero
`timescale 1ns/1ps
module arc_config
    import arc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic power_down,
    input wire logic start_conversion,
    input wire logic sample_done,
    output logic [7:0] reg_rdata,
    output logic chop_enable,
    output logic chop_swap,
    output logic external_clock_select,
    output logic single_shot_mode,
    output logic low_latency_filter,
    output logic [3:0] output_rate_code,
    output logic rate_code_valid,
    output logic converting,
    output logic ref_low_threshold_monitor,
    output logic ref_third_span_monitor,
    output logic ref_pull_together,
    output logic pos_ref_buffer_bypass,
    output logic neg_ref_buffer_bypass,
    output logic [1:0] reference_input_select,
    output logic reference_select_valid,
    output logic internal_ref_on,
    output logic output_rail_monitor_enable,
    output logic low_side_switch_close,
    output logic [3:0] excitation_current_magnitude
);
    // ---------------------------------------------------------------
    // Register storage
    // ---------------------------------------------------------------
    logic [7:0] conversion_rate_config;
    logic [7:0] reference_config;
    logic [7:0] excitation_magnitude_config;

    always_ff @(posedge clk) begin
        if (reset) begin
            conversion_rate_config <= RESET_RATE; // [RULE1]
        end else if (reg_write && reg_addr == ADDR_RATE) begin
            conversion_rate_config <= reg_wdata; // [RULE1]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reference_config <= RESET_REF; // [RULE14]
        end else if (reg_write && reg_addr == ADDR_REF) begin
            reference_config <= reg_wdata; // [RULE14]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            excitation_magnitude_config <= RESET_EXC; // [RULE15]
        end else if (reg_write && reg_addr == ADDR_EXC) begin
            // Reserved bits dropped on the way in
            excitation_magnitude_config <= reg_wdata & EXC_WRITE_MASK; // [RULE19]
        end
    end

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    // Unmapped addresses read zero; data stands until next read
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                ADDR_RATE: reg_rdata <= conversion_rate_config;
                ADDR_REF: reg_rdata <= reference_config;
                ADDR_EXC: reg_rdata <= excitation_magnitude_config & EXC_WRITE_MASK; // [RULE19]
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Decoded controls
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            external_clock_select <= RESET_RATE[RATE_CLK_BIT];
            single_shot_mode <= RESET_RATE[RATE_MODE_BIT];
            low_latency_filter <= RESET_RATE[RATE_FILTER_BIT];
            output_rate_code <= RESET_RATE[3:0];
            rate_code_valid <= 1'b1;
            chop_enable <= RESET_RATE[RATE_CHOP_BIT];
        end else begin
            chop_enable <= conversion_rate_config[RATE_CHOP_BIT]; // [RULE2]
            external_clock_select <= conversion_rate_config[RATE_CLK_BIT]; // [RULE3]
            single_shot_mode <= conversion_rate_config[RATE_MODE_BIT]; // [RULE4]
            low_latency_filter <= conversion_rate_config[RATE_FILTER_BIT]; // [RULE5]
            output_rate_code <= conversion_rate_config[3:0]; // [RULE6]
            rate_code_valid <= conversion_rate_config[3:0] != RATE_CODE_RESERVED; // [RULE6]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ref_low_threshold_monitor <= 1'b0;
            ref_third_span_monitor <= 1'b0;
            ref_pull_together <= 1'b0;
            pos_ref_buffer_bypass <= RESET_REF[REF_POS_BUF_BIT];
            neg_ref_buffer_bypass <= RESET_REF[REF_NEG_BUF_BIT];
            reference_input_select <= RESET_REF[3:2];
            reference_select_valid <= 1'b1;
            internal_ref_on <= 1'b0;
        end else begin
            ref_low_threshold_monitor <= reference_config[7:6] != MON_OFF; // [RULE7]
            ref_third_span_monitor <= reference_config[7:6] == MON_LOW_THIRD; // [RULE7]
            ref_pull_together <= reference_config[7:6] == MON_LOW_PULL; // [RULE7]
            pos_ref_buffer_bypass <= reference_config[REF_POS_BUF_BIT]; // [RULE8]
            neg_ref_buffer_bypass <= reference_config[REF_NEG_BUF_BIT]; // [RULE9]
            reference_input_select <= reference_config[3:2]; // [RULE10]
            reference_select_valid <= reference_config[3:2] != REFSRC_RESERVED; // [RULE10]
            // Reserved code treated as off
            internal_ref_on <= (reference_config[1:0] == IREF_ALWAYS) ||
                (reference_config[1:0] == IREF_ON_PD_OFF && !power_down); // [RULE11]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            output_rail_monitor_enable <= 1'b0;
            low_side_switch_close <= 1'b0;
            excitation_current_magnitude <= EXC_CURRENT_OFF;
        end else begin
            output_rail_monitor_enable <= excitation_magnitude_config[EXC_RAIL_BIT]; // [RULE18]
            // Power-down wins over the switch bit
            low_side_switch_close <= excitation_magnitude_config[EXC_SWITCH_BIT] &&
                !power_down; // [RULE16]
            excitation_current_magnitude <= excitation_magnitude_config[3:0]; // [RULE17]
        end
    end

    // ---------------------------------------------------------------
    // Conversion sequencing
    // ---------------------------------------------------------------
    // Continuous runs until power-down; single-shot stops after one
    // result, or one chopped pair when chop is on.
    arc_conv_state_t state;
    logic pair_second;

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= ARC_IDLE;
        end else begin
            case (state)
                ARC_IDLE: begin
                    if (start_conversion && !power_down) begin
                        state <= ARC_CONVERT;
                    end
                end
                ARC_CONVERT: begin
                    if (power_down) begin
                        state <= ARC_IDLE;
                    end else if (sample_done && single_shot_mode &&
                                 (!chop_enable || pair_second)) begin // [RULE4]
                        state <= ARC_DONE;
                    end
                end
                ARC_DONE: begin
                    state <= ARC_IDLE;
                end
                default: begin
                    state <= ARC_IDLE;
                end
            endcase
        end
    end

    // Input polarity flips every sample while chopping
    always_ff @(posedge clk) begin
        if (reset) begin
            pair_second <= 1'b0;
        end else if (state != ARC_CONVERT || !chop_enable) begin
            pair_second <= 1'b0;
        end else if (sample_done) begin
            pair_second <= !pair_second; // [RULE2]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            converting <= 1'b0;
            chop_swap <= 1'b0;
        end else begin
            converting <= state == ARC_CONVERT;
            chop_swap <= pair_second;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_rate_reset: assert property (@(posedge clk)
        $fell(reset) |-> conversion_rate_config == RESET_RATE) // [RULE1]
        else $error("rate register reset value wrong");
    a_ref_reset: assert property (@(posedge clk)
        $fell(reset) |-> reference_config == RESET_REF) // [RULE14]
        else $error("reference register reset value wrong");
    a_exc_write: assert property (@(posedge clk) disable iff (reset)
        reg_write && reg_addr == ADDR_EXC |=> excitation_magnitude_config[5:4] == 2'h0 &&
        excitation_magnitude_config[3:0] == $past(reg_wdata[3:0])) // [RULE15]
        else $error("excitation register write wrong");
    a_exc_read_zero: assert property (@(posedge clk) disable iff (reset)
        reg_read && reg_addr == ADDR_EXC |=> reg_rdata[5:4] == 2'h0) // [RULE19]
        else $error("reserved bits read nonzero");
    a_switch_pd: assert property (@(posedge clk) disable iff (reset)
        power_down |=> !low_side_switch_close) // [RULE16]
        else $error("switch closed in power-down");
    a_rate_decode: assert property (@(posedge clk) disable iff (reset)
        reg_write && reg_addr == ADDR_RATE |-> ##2 single_shot_mode == $past(reg_wdata[5], 2)
        && output_rate_code == $past(reg_wdata[3:0], 2)) // [RULE4]
        else $error("rate fields not decoded");
    a_monitor_third: assert property (@(posedge clk) disable iff (reset)
        ref_third_span_monitor |-> ref_low_threshold_monitor && !ref_pull_together) // [RULE7]
        else $error("monitor decode inconsistent");
    a_iref_pd: assert property (@(posedge clk) disable iff (reset)
        $past(reference_config[1:0]) == IREF_ON_PD_OFF && $past(power_down)
        |-> !internal_ref_on) // [RULE11]
        else $error("internal reference on in power-down");
    a_chop_toggle: assert property (@(posedge clk) disable iff (reset)
        state == ARC_CONVERT && chop_enable && sample_done && !power_down
        |=> pair_second != $past(pair_second)) // [RULE2]
        else $error("chop polarity did not flip");

    c_single_shot: cover property (@(posedge clk) disable iff (reset)
        state == ARC_CONVERT ##1 state == ARC_DONE);
    c_chop_pair: cover property (@(posedge clk) disable iff (reset)
        chop_swap ##1 !chop_swap);
    c_switch_closed: cover property (@(posedge clk) disable iff (reset)
        low_side_switch_close ##1 !low_side_switch_close);
endmodule : arc_config
